// File: hw/spdc_top.sv
// Purpose: step/direction controller with trapezoidal ramp, AXI4-Lite regs
// Assumes: aclk 100 MHz, aresetn is the power-up reset
// Notes: a soft reset command keeps rate and ramp settings
//
// Behaviour
// R1 - software programs max rate 1 to 10000
// R2 - ramp steps used for both acceleration and deceleration
// R3 - rate and ramp survive soft reset
// R4 - software loads rate and ramp before moving
// R5 - accepted move follows trajectory from stored settings
// R6 - relative count magnitude pulses, sign picks direction
// R7 - half-step mode counts half steps
// R8 - accepting a move clears its completion flag
// R9 - last pulse sets the selected completion flag
// R10 - absolute move uses target minus current position
// R11 - target and position are signed 32 bit
// R12 - origin command sets home position
// R13 - absolute position readable at any time
// R14 - moves ignored while a move runs
// R15 - mode select one is controller, others driver
// R16 - profile starts and ends at max/8
// R17 - direction high for negative, low positive
// R18 - output 1 direction, output 2 step
// R19 - direction stable across whole move
// R20 - abort stops at once, no completion flag
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module spdc_top #(
	parameter int unsigned MAX_RATE = spdc_pkg::RATE_MAX,
	parameter int unsigned FLAGS = 32
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic dout1_dir,
	output logic dout2_step
);
	initial begin
		if (MAX_RATE < 8 || MAX_RATE > 16383) $error("spdc_top: MAX_RATE unsupported");
		if (FLAGS < 1 || FLAGS > 32) $error("spdc_top: FLAGS must be 1..32");
	end

	typedef enum logic [2:0] {
		SPDC_IDLE, SPDC_SETUP, SPDC_CALC_RATE, SPDC_CALC_PER, SPDC_HIGH, SPDC_LOW
	} spdc_state_t;

	// clamp a written rate to the supported maximum
	function automatic logic [13:0] spdc_clamp_rate(input logic [31:0] v);
		if (v > 32'(MAX_RATE)) return 14'(MAX_RATE);
		return v[13:0];
	endfunction : spdc_clamp_rate

	// magnitude of a signed 33-bit difference as unsigned 32 bits
	function automatic logic [31:0] spdc_mag(input logic [32:0] v);
		logic [32:0] n;
		n = v[32] ? (33'h0 - v) : v;
		return n[31:0];
	endfunction : spdc_mag

	////////////////////////////////////////////////////////////////
	// bus state
	logic aw_got_r; // write address captured
	logic w_got_r; // write data captured
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic wr_fire; // both halves present, response slot free
	logic [31:0] rd_word; // read mux output
	logic rd_hit; // read address decodes

	// software visible settings and state
	logic [13:0] rate_r; // max pulses per second, zero until loaded
	logic [15:0] ramp_r; // steps used to ramp up and down
	logic [31:0] arg_r; // signed count or target
	logic [1:0] mode_r; // channel_mode_select
	logic [FLAGS-1:0] done_r; // completion flags
	logic signed [31:0] pos_r; // absolute position from home
	logic [31:0] progress_r; // pulses emitted this move

	// motion state
	spdc_state_t st_r;
	logic [31:0] total_r; // pulses in this move
	logic [4:0] flag_sel_r; // flag chosen by the move
	logic [31:0] tmr_r; // cycles since pulse start or setup
	logic [31:0] period_r; // cycles for current pulse
	logic [13:0] cur_rate_r; // rate for current pulse

	// command decode, only full word writes to the command register act
	logic cmd_wr;
	logic busy;
	logic do_rel, do_abs, do_abort, do_origin, do_soft;
	logic [32:0] abs_diff;
	logic [4:0] cmd_flag;

	assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
	assign cmd_wr = wr_fire && awaddr_r[7:2] == spdc_pkg::OFS_CMD[7:2] && wstrb_r == 4'hf;
	assign busy = st_r != SPDC_IDLE;
	assign do_soft = cmd_wr && wdata_r[spdc_pkg::CMD_SOFTRST_BIT];
	assign do_abort = cmd_wr && wdata_r[spdc_pkg::CMD_ABORT_BIT];
	// moves need a loaded rate and an idle channel
	// an abort in the same word wins, so no half-accepted move is left behind
	assign do_rel = cmd_wr && wdata_r[spdc_pkg::CMD_REL_BIT] && !busy && rate_r != 0 && !do_soft
		&& !do_abort; // R14 R4
	assign do_abs = cmd_wr && wdata_r[spdc_pkg::CMD_ABS_BIT] && !wdata_r[spdc_pkg::CMD_REL_BIT]
		&& !busy && rate_r != 0 && !do_soft && !do_abort; // R14
	assign do_origin = cmd_wr && wdata_r[spdc_pkg::CMD_ORIGIN_BIT] && !busy;
	assign abs_diff = {arg_r[31], arg_r} - {pos_r[31], pos_r}; // R10 R11
	assign cmd_flag = wdata_r[spdc_pkg::CMD_FLAG_LSB +: 5];

	////////////////////////////////////////////////////////////////
	// write address and data channels, taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			s_axi_awready <= 1'b0;
			awaddr_r <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_got_r <= 1'b1;
			s_axi_awready <= 1'b0;
			awaddr_r <= s_axi_awaddr;
		end else if (wr_fire || !aw_got_r) begin
			aw_got_r <= 1'b0;
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_got_r <= 1'b0;
			s_axi_wready <= 1'b0;
			wdata_r <= '0;
			wstrb_r <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_got_r <= 1'b1;
			s_axi_wready <= 1'b0;
			wdata_r <= s_axi_wdata;
			wstrb_r <= s_axi_wstrb;
		end else if (wr_fire || !w_got_r) begin
			w_got_r <= 1'b0;
			s_axi_wready <= 1'b1;
		end
	end

	// write response, unmapped or read-only offsets answer slverr
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= spdc_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			unique case (awaddr_r[7:2])
				spdc_pkg::OFS_CMD[7:2], spdc_pkg::OFS_RATE[7:2], spdc_pkg::OFS_RAMP[7:2],
				spdc_pkg::OFS_ARG[7:2], spdc_pkg::OFS_DONE[7:2]: s_axi_bresp <= spdc_pkg::RESP_OKAY;
				default: s_axi_bresp <= spdc_pkg::RESP_SLVERR;
			endcase
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////
	// settings; only power-up reset clears them, soft reset leaves them
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rate_r <= spdc_pkg::RATE_RST; // R3 R4
			ramp_r <= spdc_pkg::RAMP_RST;
			arg_r <= '0;
		end else if (wr_fire) begin
			if (awaddr_r[7:2] == spdc_pkg::OFS_RATE[7:2] && wstrb_r[1:0] == 2'h3)
				rate_r <= spdc_clamp_rate({16'h0000, wdata_r[15:0]}); // R1
			if (awaddr_r[7:2] == spdc_pkg::OFS_RAMP[7:2] && wstrb_r[1:0] == 2'h3)
				ramp_r <= wdata_r[15:0]; // R2
			if (awaddr_r[7:2] == spdc_pkg::OFS_ARG[7:2]) begin
				for (int b = 0; b < 4; b++) begin
					if (wstrb_r[b]) arg_r[b*8 +: 8] <= wdata_r[b*8 +: 8];
				end
			end
		end
	end

	// mode is latched from every accepted move
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_r <= spdc_pkg::MODE_RST;
		end else if (do_rel || do_abs) begin
			// half-step mode changes only the meaning of a count, not the logic
			mode_r <= wdata_r[spdc_pkg::CMD_MODE_LSB +: 2]; // R15 R7
		end
	end

	////////////////////////////////////////////////////////////////
	// completion flags: hardware set beats a same-cycle write-1 clear
	logic last_done; // final pulse of the move just ended
	assign last_done = st_r == SPDC_LOW && tmr_r + 1 >= period_r && progress_r == total_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			done_r <= '0;
		end else begin
			for (int i = 0; i < FLAGS; i++) begin
				if (i == int'(flag_sel_r) && last_done && !do_abort) begin
					done_r[i] <= 1'b1; // R9
				end else if ((do_rel || do_abs) && i == int'(cmd_flag)) begin
					done_r[i] <= (do_rel ? arg_r : spdc_mag(abs_diff)) == 0; // R8
				end else if (wr_fire && awaddr_r[7:2] == spdc_pkg::OFS_DONE[7:2]
					&& wstrb_r == 4'hf && wdata_r[i]) begin
					done_r[i] <= 1'b0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// profile arithmetic through one shared divider
	logic [13:0] floor_rate; // one eighth of max, at least one
	logic [13:0] span; // max minus floor
	logic [31:0] k_step; // steps into the nearer ramp
	logic [31:0] left; // pulses after the current one
	logic div_start, div_busy, div_done;
	logic [31:0] div_num, div_den, div_quo;

	assign floor_rate = (rate_r >> spdc_pkg::FLOOR_SHIFT) == 0 ? 14'h0001
		: rate_r >> spdc_pkg::FLOOR_SHIFT; // R16
	assign span = rate_r - floor_rate;
	assign left = total_r - progress_r - 1;
	// same ramp length up and down, cut short on short moves
	assign k_step = progress_r < left ? progress_r : left; // R2

	always_comb begin
		div_start = 1'b0;
		div_num = '0;
		div_den = 32'h1;
		if (st_r == SPDC_CALC_RATE && !div_busy && !div_done) begin
			div_start = ramp_r != 0 && k_step < {16'h0000, ramp_r};
			div_num = 32'(span) * (k_step < {16'h0000, ramp_r} ? k_step : 32'h0); // R5
			div_den = {16'h0000, ramp_r};
		end else if (st_r == SPDC_CALC_PER && !div_busy && !div_done) begin
			div_start = 1'b1;
			div_num = spdc_pkg::CLK_HZ;
			div_den = {18'h00000, cur_rate_r};
		end
	end

	spdc_div #(
		.W(32)
	) u_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(div_start),
		.num(div_num),
		.den(div_den),
		.busy(div_busy),
		.done(div_done),
		.quo(div_quo)
	);

	////////////////////////////////////////////////////////////////
	// motion sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn || do_soft) begin
			st_r <= SPDC_IDLE;
			dout1_dir <= 1'b0;
			dout2_step <= 1'b0;
			total_r <= '0;
			flag_sel_r <= '0;
			tmr_r <= '0;
			period_r <= '0;
			cur_rate_r <= '0;
		end else if (do_abort) begin
			// abort drops the pulse at once, no flag
			st_r <= SPDC_IDLE; // R20
			dout2_step <= 1'b0;
		end else begin
			tmr_r <= tmr_r + 1;
			unique case (st_r)
				SPDC_IDLE: begin
					if (do_rel || do_abs) begin
						total_r <= do_rel ? spdc_mag({arg_r[31], arg_r}) : spdc_mag(abs_diff); // R6 R10
						dout1_dir <= do_rel ? arg_r[31] : abs_diff[32]; // R17 R18
						flag_sel_r <= cmd_flag;
						tmr_r <= '0;
						// zero-length moves finish on acceptance
						if ((do_rel ? arg_r : spdc_mag(abs_diff)) != 0) st_r <= SPDC_SETUP;
					end
				end
				SPDC_SETUP: begin
					// direction settles before the first pulse
					if (tmr_r + 1 >= spdc_pkg::DIR_SETUP_CYC) st_r <= SPDC_CALC_RATE; // R19
				end
				SPDC_CALC_RATE: begin
					if (ramp_r == 0 || k_step >= {16'h0000, ramp_r}) begin
						cur_rate_r <= rate_r;
						st_r <= SPDC_CALC_PER;
					end else if (div_done) begin
						cur_rate_r <= floor_rate + div_quo[13:0]; // R16
						st_r <= SPDC_CALC_PER;
					end
				end
				SPDC_CALC_PER: begin
					if (div_done) begin
						// long periods only slow the motor, never exceed max
						period_r <= div_quo < 32'(2 * spdc_pkg::STEP_HIGH_CYC)
							? 32'(2 * spdc_pkg::STEP_HIGH_CYC) : div_quo; // R1
						dout2_step <= 1'b1; // R18
						tmr_r <= '0;
						st_r <= SPDC_HIGH;
					end
				end
				SPDC_HIGH: begin
					if (tmr_r + 1 >= spdc_pkg::STEP_HIGH_CYC) begin
						dout2_step <= 1'b0;
						st_r <= SPDC_LOW;
					end
				end
				SPDC_LOW: begin
					if (tmr_r + 1 >= period_r) begin
						// direction is held until the last pulse period ends
						st_r <= progress_r == total_r ? SPDC_IDLE : SPDC_CALC_RATE; // R19 R9
					end
				end
			endcase
		end
	end

	// position and progress follow emitted pulses only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pos_r <= '0;
			progress_r <= '0;
		end else if (do_soft || do_origin) begin
			pos_r <= '0; // R12
			progress_r <= '0;
		end else if (do_rel || do_abs) begin
			progress_r <= '0;
		end else if (st_r == SPDC_CALC_PER && div_done && !do_abort) begin
			pos_r <= dout1_dir ? pos_r - 1 : pos_r + 1; // R11 R20
			progress_r <= progress_r + 1;
		end
	end

	////////////////////////////////////////////////////////////////
	// read channel, one cycle after the address is taken
	always_comb begin
		rd_hit = 1'b1;
		rd_word = '0;
		unique case (s_axi_araddr[7:2])
			spdc_pkg::OFS_CMD[7:2]: rd_word = {14'h0, mode_r, 16'h0};
			spdc_pkg::OFS_RATE[7:2]: rd_word = {18'h0, rate_r};
			spdc_pkg::OFS_RAMP[7:2]: rd_word = {16'h0, ramp_r};
			spdc_pkg::OFS_ARG[7:2]: rd_word = arg_r;
			// status: busy in bit 0, direction in bit 1, mode in [17:16]
			spdc_pkg::OFS_STATUS[7:2]: rd_word = {14'h0, mode_r, 14'h0, dout1_dir, busy};
			spdc_pkg::OFS_DONE[7:2]: rd_word = 32'(done_r);
			spdc_pkg::OFS_ABSPOS[7:2]: rd_word = pos_r; // R13
			spdc_pkg::OFS_PROGRESS[7:2]: rd_word = progress_r;
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= spdc_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_hit ? spdc_pkg::RESP_OKAY : spdc_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end

	// protection bits carry no meaning here
	logic unused_prot;
	assign unused_prot = ^{s_axi_awprot, s_axi_arprot};
endmodule : spdc_top
`default_nettype wire

// File: hw/spdc_pkg.sv
// Purpose: shared constants for the step/direction pulse controller
// Assumes: 100 MHz system clock, 32-bit AXI4-Lite register bus
// Notes: all offsets are byte addresses of aligned words
package spdc_pkg;
	// clock and timing
	localparam int unsigned CLK_HZ = 100_000_000; // system clock rate
	localparam int unsigned CLK_PERIOD_PS = 10_000; // one clock period
	localparam int unsigned STEP_HIGH_NS = 2000; // step pulse high time
	localparam int unsigned DIR_SETUP_NS = 5000; // direction to first pulse
	// least times round up to whole cycles
	localparam int unsigned STEP_HIGH_CYC = (STEP_HIGH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned DIR_SETUP_CYC = (DIR_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// rate limits in pulses per second
	localparam int unsigned RATE_MIN = 1;
	localparam int unsigned RATE_MAX = 10000;
	localparam int unsigned FLOOR_SHIFT = 3; // floor is one eighth of max
	// register byte offsets
	localparam logic [7:0] OFS_CMD = 8'h00;
	localparam logic [7:0] OFS_RATE = 8'h04;
	localparam logic [7:0] OFS_RAMP = 8'h08;
	localparam logic [7:0] OFS_ARG = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_DONE = 8'h14;
	localparam logic [7:0] OFS_ABSPOS = 8'h18;
	localparam logic [7:0] OFS_PROGRESS = 8'h1c;
	// command register fields
	localparam int CMD_REL_BIT = 0;
	localparam int CMD_ABS_BIT = 1;
	localparam int CMD_ABORT_BIT = 2;
	localparam int CMD_ORIGIN_BIT = 3;
	localparam int CMD_SOFTRST_BIT = 4;
	localparam int CMD_MODE_LSB = 8;
	localparam int CMD_FLAG_LSB = 16;
	// mode codes carried by channel_mode_select
	localparam logic [1:0] MODE_CONTROLLER = 2'h1;
	localparam logic [1:0] MODE_FULL_STEP = 2'h2;
	localparam logic [1:0] MODE_HALF_STEP = 2'h3;
	// reset values
	localparam logic [13:0] RATE_RST = 14'h0000; // zero means not loaded
	localparam logic [15:0] RAMP_RST = 16'h0000;
	localparam logic [1:0] MODE_RST = MODE_CONTROLLER;
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : spdc_pkg

// File: hw/spdc_div.sv
// Purpose: iterative unsigned divider used for the speed profile
// Assumes: one division at a time, start only while not busy
// Notes: one quotient bit per clock, result after W+1 cycles
`timescale 1ns/1ps
`default_nettype none
module spdc_div #(
	parameter int W = 32
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic start,
	input wire logic [W-1:0] num,
	input wire logic [W-1:0] den,
	output logic busy,
	output logic done,
	output logic [W-1:0] quo
);
	initial begin
		if (W < 2 || W > 63) $error("spdc_div: width out of range");
	end

	logic [W-1:0] den_r; // divisor held for the run
	logic [W:0] rem_r; // partial remainder, one spare bit
	logic [$clog2(W+1)-1:0] cnt_r; // bits still to produce
	logic [W:0] trial; // remainder after shifting in next bit

	assign trial = {rem_r[W-1:0], quo[W-1]};

	////////////////////////////////////////////////////////////////
	// restoring division, dividend shifts out of the quotient reg
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy <= 1'b0;
			done <= 1'b0;
			quo <= '0;
			rem_r <= '0;
			den_r <= '0;
			cnt_r <= '0;
		end else begin
			done <= 1'b0;
			if (start && !busy) begin
				busy <= 1'b1;
				quo <= num;
				den_r <= den;
				rem_r <= '0;
				cnt_r <= ($clog2(W+1))'(W);
			end else if (busy) begin
				// divide by zero yields all ones, harmless here
				if (trial >= {1'b0, den_r}) begin
					rem_r <= trial - {1'b0, den_r};
					quo <= {quo[W-2:0], 1'b1};
				end else begin
					rem_r <= trial;
					quo <= {quo[W-2:0], 1'b0};
				end
				cnt_r <= cnt_r - 1'b1;
				if (cnt_r == 1) begin
					busy <= 1'b0;
					done <= 1'b1;
				end
			end
		end
	end
endmodule : spdc_div
`default_nettype wire

// File: sim/spdc_chk.sv
// Purpose: bus answer and step/direction timing checks for spdc_top
// Assumes: bound to spdc_top, single aclk domain
// Notes: the low-run and direction-age counters saturate so long idle spans stay legal
`timescale 1ns/1ps
`default_nettype none
module spdc_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic dout1_dir,
	input wire logic dout2_step
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [15:0] hi_r; // cycles step has been high
	logic [15:0] lo_r; // cycles step has been low
	logic [15:0] age_r; // cycles since dir last moved
	logic dir_q_r; // dir one cycle back
	////////////////////////////////
	// step run lengths; low count starts saturated so the first pulse is free
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hi_r <= 16'h0000;
			lo_r <= 16'hffff;
		end else begin
			hi_r <= dout2_step ? hi_r + 16'h0001 : 16'h0000;
			lo_r <= dout2_step ? 16'h0000 : lo_r + {15'h0000, lo_r != 16'hffff};
		end
	end
	// age of the direction level
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dir_q_r <= 1'b0;
			age_r <= 16'hffff;
		end else begin
			dir_q_r <= dout1_dir;
			age_r <= (dout1_dir != dir_q_r) ? 16'h0000 : age_r + {15'h0000, age_r != 16'hffff};
		end
	end
	////////////////////////////////
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_wr_answer: assert property (s_wr_take |-> ##[1:3] s_axi_bvalid)
		else $error("write not answered");
	a_wr_ro_err: assert property (s_wr_take ##0 (s_axi_awaddr == spdc_pkg::OFS_STATUS)
		|-> ##[1:3] (s_axi_bvalid && s_axi_bresp == spdc_pkg::RESP_SLVERR))
		else $error("read-only write not refused");
	a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
	a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
		else $error("read not answered");
	a_rd_unmapped: assert property (s_rd_take ##0 (s_axi_araddr[7:2] > 6'h07)
		|=> s_axi_rresp == spdc_pkg::RESP_SLVERR)
		else $error("unmapped read not refused");
	a_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
	a_step_width: assert property ($fell(dout2_step) |-> hi_r <= 16'h00c8)
		else $error("step pulse too long");
	a_step_gap: assert property ($rose(dout2_step) |-> lo_r >= 16'h00c8)
		else $error("step pulses too close");
	a_dir_setup: assert property ($rose(dout2_step) |-> age_r >= 16'h01f3)
		else $error("direction set too late");
	a_dir_hold: assert property (dout2_step |-> $stable(dout1_dir))
		else $error("direction moved during pulse");
endmodule : spdc_chk
`default_nettype wire

// File: sim/spdc_drv_model.sv
// Purpose: stepper driver seen from its step and direction inputs
// Assumes: step counted on its rising edge, dir high means negative
// Notes: keeps its own position, never cleared by origin or soft reset
`timescale 1ns/1ps
`default_nettype none
module spdc_drv_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic dir,
	input wire logic step,
	output int steps,
	output int pos,
	output int errs
);
	logic step_q_r; // step one cycle back
	logic dir_q_r; // dir one cycle back
	// count pulses, move the shaft, flag a direction slip mid pulse
	always_ff @(posedge aclk) begin
		step_q_r <= step;
		dir_q_r <= dir;
		if (!aresetn) begin
			steps <= 0;
			pos <= 0;
			errs <= 0;
		end else if (step && !step_q_r) begin
			steps <= steps + 1;
			pos <= dir ? pos - 1 : pos + 1;
		end else if (step && dir != dir_q_r) begin
			errs <= errs + 1;
		end
	end
endmodule : spdc_drv_model
`default_nettype wire

// File: sim/spdc_top_tb.sv
// Purpose: directed register-bus tests of spdc_top with a driver model
// Assumes: rate 10000 pps so one pulse period is about 10000 cycles
// Notes: bus tasks hold every request until its ready edge
`timescale 1ns/1ps
`default_nettype none
module spdc_top_tb;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [2:0] s_axi_awprot = 3'h0; // ignored by the block
	logic s_axi_awvalid = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hf; // full words only
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [2:0] s_axi_arprot = 3'h0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic dout1_dir, dout2_step;
	int fails = 0;
	int checked = 0;
	int cyc = 0; // timeout counter
	int m_steps, m_pos, m_errs; // driver model view
	logic [31:0] rd;
	logic [1:0] rs;
	spdc_top u_dut (.*);
	spdc_drv_model u_drv (.aclk(aclk), .aresetn(aresetn), .dir(dout1_dir),
		.step(dout2_step), .steps(m_steps), .pos(m_pos), .errs(m_errs));
	always #5 aclk = ~aclk;
	////////////////////////////////
	task automatic end_sim();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	// write with address and data offered together, answer code compared
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && s_axi_awready === 1'b1) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_ok && s_axi_wready === 1'b1) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		chk({30'h0, s_axi_bresp}, {30'h0, e});
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask : wr
	task automatic rd_reg(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : rd_reg
	// masked read compare
	task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		rd_reg(a);
		chk(rd & m, e);
	endtask : rchk
	// command word: op bits, mode, completion flag index
	function automatic logic [31:0] cmd(input logic [4:0] op, input logic [1:0] m,
		input logic [4:0] f);
		return {11'h000, f, 6'h00, m, 3'h0, op};
	endfunction : cmd
	task automatic wait_idle();
		do begin
			repeat (200) @(posedge aclk);
			rd_reg(spdc_pkg::OFS_STATUS);
		end while (rd[0] !== 1'b0);
	endtask : wait_idle
	////////////////////////////////
	// hang guard, sized for about nine pulse periods
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			fails++;
			end_sim();
		end
	end
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd_reg(8'h20);
		chk({30'h0, rs}, {30'h0, spdc_pkg::RESP_SLVERR});
		wr(spdc_pkg::OFS_STATUS, 32'h0000_0000, spdc_pkg::RESP_SLVERR);
		rchk(spdc_pkg::OFS_ABSPOS, 32'hffff_ffff, 32'h0000_0000);
		// move before rate is loaded goes nowhere
		wr(spdc_pkg::OFS_ARG, 32'h0000_0002, spdc_pkg::RESP_OKAY);
		wr(spdc_pkg::OFS_CMD, cmd(5'h01, 2'h1, 5'h05), spdc_pkg::RESP_OKAY);
		rchk(spdc_pkg::OFS_STATUS, 32'h0000_0001, 32'h0000_0000);
		wr(spdc_pkg::OFS_RATE, 32'h0000_2710, spdc_pkg::RESP_OKAY);
		wr(spdc_pkg::OFS_RAMP, 32'h0000_0000, spdc_pkg::RESP_OKAY);
		// relative +2, a second move offered while busy
		wr(spdc_pkg::OFS_CMD, cmd(5'h01, 2'h1, 5'h05), spdc_pkg::RESP_OKAY);
		rchk(spdc_pkg::OFS_STATUS, 32'h0003_0003, 32'h0001_0001);
		wr(spdc_pkg::OFS_ARG, 32'hffff_fff7, spdc_pkg::RESP_OKAY);
		wr(spdc_pkg::OFS_CMD, cmd(5'h01, 2'h1, 5'h06), spdc_pkg::RESP_OKAY);
		wait_idle();
		rchk(spdc_pkg::OFS_ABSPOS, 32'hffff_ffff, 32'h0000_0002);
		rchk(spdc_pkg::OFS_PROGRESS, 32'hffff_ffff, 32'h0000_0002);
		rchk(spdc_pkg::OFS_DONE, 32'h0000_0060, 32'h0000_0020);
		chk(m_steps, 2);
		// absolute to -1 in half-step mode
		wr(spdc_pkg::OFS_ARG, 32'hffff_ffff, spdc_pkg::RESP_OKAY);
		wr(spdc_pkg::OFS_CMD, cmd(5'h02, 2'h3, 5'h06), spdc_pkg::RESP_OKAY);
		rchk(spdc_pkg::OFS_STATUS, 32'h0003_0003, 32'h0003_0003);
		wait_idle();
		rchk(spdc_pkg::OFS_ABSPOS, 32'hffff_ffff, 32'hffff_ffff);
		rchk(spdc_pkg::OFS_PROGRESS, 32'hffff_ffff, 32'h0000_0003);
		rchk(spdc_pkg::OFS_DONE, 32'h0000_0040, 32'h0000_0040);
		chk(m_pos, -1);
		// new home, then a move aborted after its first pulse
		wr(spdc_pkg::OFS_CMD, cmd(5'h08, 2'h1, 5'h00), spdc_pkg::RESP_OKAY);
		rchk(spdc_pkg::OFS_ABSPOS, 32'hffff_ffff, 32'h0000_0000);
		wr(spdc_pkg::OFS_ARG, 32'h0000_0005, spdc_pkg::RESP_OKAY);
		wr(spdc_pkg::OFS_CMD, cmd(5'h01, 2'h2, 5'h07), spdc_pkg::RESP_OKAY);
		while (m_steps == 5) @(posedge aclk);
		rchk(spdc_pkg::OFS_ABSPOS, 32'hffff_ffff, 32'h0000_0001);
		wr(spdc_pkg::OFS_CMD, cmd(5'h04, 2'h2, 5'h07), spdc_pkg::RESP_OKAY);
		rchk(spdc_pkg::OFS_STATUS, 32'h0000_0001, 32'h0000_0000);
		rchk(spdc_pkg::OFS_ABSPOS, 32'hffff_ffff, 32'h0000_0001);
		rchk(spdc_pkg::OFS_DONE, 32'h0000_0080, 32'h0000_0000);
		// soft reset keeps rate; reused flag clears on accept
		wr(spdc_pkg::OFS_CMD, cmd(5'h10, 2'h1, 5'h00), spdc_pkg::RESP_OKAY);
		rchk(spdc_pkg::OFS_ABSPOS, 32'hffff_ffff, 32'h0000_0000);
		wr(spdc_pkg::OFS_ARG, 32'h0000_0001, spdc_pkg::RESP_OKAY);
		wr(spdc_pkg::OFS_CMD, cmd(5'h02, 2'h1, 5'h05), spdc_pkg::RESP_OKAY);
		rchk(spdc_pkg::OFS_DONE, 32'h0000_0020, 32'h0000_0000);
		rchk(spdc_pkg::OFS_STATUS, 32'h0000_0003, 32'h0000_0001);
		wait_idle();
		rchk(spdc_pkg::OFS_ABSPOS, 32'hffff_ffff, 32'h0000_0001);
		rchk(spdc_pkg::OFS_DONE, 32'h0000_0020, 32'h0000_0020);
		chk(m_steps, 7);
		chk(m_errs, 0);
		end_sim();
	end
endmodule : spdc_top_tb
bind spdc_top spdc_chk u_chk (.*);
`default_nettype wire
